// *** tpf_formatter.sv ***
// Purpose: Trace packet formatter merging software, watchpoint, timestamp,
//          overflow and sync packets into one byte stream.
// Assumes: All inputs come from logic on clk_sys_in; ce_in freezes all state.
// Notes:   Bytes leave through a 32-entry FIFO, either as bytes or serially.
//
// Summary of operation
// - Each packet opens with a header; all-zero header starts a sync packet.
// - Nonzero header with low bits 00 is a protocol packet, 0-4 payload bytes.
// - Header with nonzero low bits is a source packet of 1, 2 or 4 bytes.
// - Non-sync packets are one to five bytes including the header.
// - Header goes first, payload in order, each byte LSB first.
// - Sync is six zero bytes then a byte with only bit 7 set.
// - Periodic sync is mandatory on a parallel port, optional on serial.
// - Sending a sync packet clears the stimulus page register to zero.
// - Overflow is the single header byte 0x70 with no payload.
// - Overflow on full stimulus buffer, full watchpoint buffer, counter wrap.
// - Local timestamp header is C, three data bits, 0000; never 000 or 111.
// - Extension header is C, data bits, 1, source bit, 00; 0-4 payload.
// - Global timestamp header is 10, type bit, 10100; 1-4 payload bytes.
// - Bit 7 of protocol bytes is continuation, except a fifth byte.
// - Emitting a local timestamp clears the timestamp counter.
// - Local timestamps are deltas; length depends on value size.
// - Synchronous timestamp of 1 to 6 goes as a single header byte.
// - All packet sources merge into one byte stream to the port.
// - Packets come from stimulus writes, hardware timestamps, sync, watchpoints.
// - Watchpoint unit packets arrive on data trace, PC sample, counter wrap.
// - Encoding is the same whatever sink takes the stream.
// - Short timestamp data bits carry the value, only 001 to 110.
// - Long timestamp payload has seven value bits per byte, low group first.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with valid/ready on both sides
module tpf_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input  wire logic         clk_sys_in,
	input  wire logic         rst_in,
	input  wire logic         ce_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} tpf_fifo_st_t;

	tpf_fifo_st_t cur_ff;
	tpf_fifo_st_t nxt_st;
	logic         push;
	logic         pop;

	// Full and empty come straight from the count, so they never lie
	assign in_ready_out  = (cur_ff.cnt != D[AW:0]);
	assign out_valid_out = (cur_ff.cnt != '0);
	assign out_data_out  = cur_ff.mem[cur_ff.rp];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// Pointer and count update
	always_comb begin
		nxt_st = cur_ff;
		if (push) begin
			nxt_st.mem[cur_ff.wp] = in_data_in;
			nxt_st.wp = cur_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_st.rp = cur_ff.rp + 1'b1;
		end
		if (push && !pop) begin
			nxt_st.cnt = cur_ff.cnt + 1'b1;
		end else if (pop && !push) begin
			nxt_st.cnt = cur_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cur_ff <= '0;
		end else if (ce_in) begin
			cur_ff <= nxt_st;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////
// Packet formatter top
module tpf_formatter
	import tpf_pkg::*;
#(
	parameter logic [31:0] SYNC_PERIOD = TPF_SYNC_PERIOD
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	input  wire logic        stim_valid_in,
	input  wire logic [7:0]  stim_port_in,
	input  wire logic [31:0] stim_data_in,
	input  wire logic [1:0]  stim_size_in,
	output logic             stim_ready_out,
	input  wire logic        hw_valid_in,
	input  wire logic [4:0]  hw_id_in,
	input  wire logic [31:0] hw_data_in,
	input  wire logic [1:0]  hw_size_in,
	output logic             hw_ready_out,
	input  wire logic        ts_enable_in,
	input  wire logic        gts_req_in,
	input  wire logic [25:0] gts_value_in,
	input  wire logic        parallel_port_in,
	input  wire logic        sync_enable_in,
	input  wire logic        serial_mode_in,
	output logic             byte_valid_out,
	input  wire logic        byte_ready_in,
	output logic [7:0]       byte_data_out,
	output logic             trace_bit_out,
	output logic             trace_bit_valid_out,
	output logic [2:0]       page_out
);

	typedef struct packed {
		tpf_state_t  st;
		logic [2:0]  idx;
		logic [2:0]  len;
		logic        is_sync;
		logic [39:0] pkt;
		logic        stim_full;
		logic [7:0]  stim_port;
		logic [31:0] stim_data;
		logic [1:0]  stim_size;
		logic        hw_full;
		logic [4:0]  hw_id;
		logic [31:0] hw_data;
		logic [1:0]  hw_size;
		logic        ovf_pend;
		logic        sync_pend;
		logic        gts_pend;
		logic [25:0] gts_val;
		logic        lts_pend;
		logic [27:0] lts_val;
		logic [27:0] ts_cnt;
		logic [2:0]  page;
		logic [31:0] sync_cnt;
		logic [7:0]  ser_sh;
		logic [3:0]  ser_cnt;
	} tpf_st_t;

	tpf_st_t     cur_ff;
	tpf_st_t     nxt_st;
	logic        fifo_in_valid;
	logic        fifo_in_ready;
	logic [7:0]  fifo_in_data;
	logic        fifo_out_valid;
	logic        fifo_out_ready;
	logic [7:0]  fifo_out_data;
	logic        sync_on;

	////////////////////////////////////////////////////////////////////////
	// Source packet: header {id, S, SS} then little-endian payload
	function automatic logic [42:0] src_pkt(input logic [4:0] id, input logic s,
		input logic [1:0] sz, input logic [31:0] data);
		logic [1:0] ss;
		logic [2:0] n;
		ss = (sz == 2'h0) ? 2'h1 : (sz == 2'h1) ? 2'h2 : 2'h3;
		n  = (sz == 2'h0) ? 3'h2 : (sz == 2'h1) ? 3'h3 : 3'h5;
		src_pkt = {n, data, id, s, ss};
	endfunction

	// Local timestamp: short form for 1 to 6, else 7-bit groups low first
	function automatic logic [42:0] lts_pkt(input logic [27:0] v);
		logic [39:0] p;
		logic [2:0]  n;
		p = '0;
		if (v >= TPF_TS_SHORT_MIN && v <= TPF_TS_SHORT_MAX) begin
			p[7:0] = {1'b0, v[2:0], TPF_LTS_LOW};
			n = TPF_ONE_BYTE;
		end else begin
			n = (v < TPF_TS_1B_LIM) ? 3'h2 : (v < TPF_TS_2B_LIM) ? 3'h3 :
				(v < TPF_TS_3B_LIM) ? 3'h4 : 3'h5;
			p[7:0] = TPF_HDR_LTS1;
			for (int i = 0; i < 4; i++) begin
				// Continuation set on all but the final payload byte
				p[8*i+8 +: 8] = {(3'(i) < n - 3'h2), v[TPF_GRP_W*i +: TPF_GRP_W]};
			end
		end
		lts_pkt = {n, p};
	endfunction

	// Global timestamp low part, always sent as a five-byte packet
	function automatic logic [42:0] gts_pkt(input logic [25:0] v);
		gts_pkt = {TPF_GTS_LEN, 3'h0, v[25:21], 1'b1, v[20:14], 1'b1, v[13:7],
			1'b1, v[6:0], TPF_HDR_GTS1};
	endfunction

	assign sync_on = parallel_port_in || sync_enable_in;

	////////////////////////////////////////////////////////////////////////
	// Input slots, pending flags, timestamp counter, arbitration and emission
	always_comb begin
		logic [42:0] bp;
		logic        launch;
		logic        took_ovf, took_sync, took_gts, took_stim, took_hw;
		bp        = '0;
		launch    = 1'b0;
		{took_ovf, took_sync, took_gts, took_stim, took_hw} = '0;
		nxt_st    = cur_ff;
		fifo_in_valid = 1'b0;
		fifo_in_data  = TPF_HDR_SYNC;

		// Local timestamp counter; a wrap is reported as overflow
		if (ts_enable_in) begin
			nxt_st.ts_cnt = cur_ff.ts_cnt + 1'b1;
		end

		// Periodic sync request; period counter restarts after each request
		if (sync_on && cur_ff.sync_cnt >= SYNC_PERIOD - 32'h0000_0001) begin
			nxt_st.sync_cnt = '0;
		end else if (sync_on) begin
			nxt_st.sync_cnt = cur_ff.sync_cnt + 32'h0000_0001;
		end

		// Byte emission; the FIFO's ready stalls the whole packet
		if (cur_ff.st == TPF_EMIT) begin
			fifo_in_valid = 1'b1;
			if (cur_ff.is_sync) begin
				fifo_in_data = (cur_ff.idx == TPF_SYNC_LEN - 3'h1) ?
					TPF_SYNC_END : TPF_HDR_SYNC;
			end else begin
				fifo_in_data = cur_ff.pkt[8*cur_ff.idx +: 8];
			end
			if (fifo_in_ready) begin
				nxt_st.idx = cur_ff.idx + 3'h1;
				if (cur_ff.idx == cur_ff.len - 3'h1) begin
					nxt_st.st = TPF_IDLE;
				end
			end
		end else begin
			// Priority: timestamp tied to last data, sync, overflow, page, data
			priority case (1'b1)
				cur_ff.lts_pend: begin
					bp = lts_pkt(cur_ff.lts_val);
					launch = 1'b1;
				end
				cur_ff.sync_pend: begin
					bp = {TPF_SYNC_LEN, 40'h00_0000_0000};
					took_sync = 1'b1;
					nxt_st.page = '0;
				end
				cur_ff.ovf_pend: begin
					bp = {TPF_ONE_BYTE, 32'h0000_0000, TPF_HDR_OVF};
					took_ovf = 1'b1;
				end
				cur_ff.stim_full && cur_ff.stim_port[7:5] != cur_ff.page: begin
					// Page change goes out as a one-byte extension packet
					bp = {TPF_ONE_BYTE, 32'h0000_0000, 1'b0, cur_ff.stim_port[7:5],
						TPF_EXT_LOW[3], TPF_SW_SRC, TPF_SRC_PROTO};
					nxt_st.page = cur_ff.stim_port[7:5];
				end
				cur_ff.stim_full: begin
					bp = src_pkt(cur_ff.stim_port[4:0], 1'b0, cur_ff.stim_size,
						cur_ff.stim_data);
					took_stim = 1'b1;
				end
				cur_ff.hw_full: begin
					bp = src_pkt(cur_ff.hw_id, 1'b1, cur_ff.hw_size,
						cur_ff.hw_data);
					took_hw = 1'b1;
				end
				cur_ff.gts_pend: begin
					bp = gts_pkt(cur_ff.gts_val);
					took_gts = 1'b1;
				end
				default: bp = '0;
			endcase
			if (bp[42:40] != 3'h0) begin
				nxt_st.st      = TPF_EMIT;
				nxt_st.idx     = '0;
				nxt_st.len     = bp[42:40];
				nxt_st.pkt     = bp[39:0];
				nxt_st.is_sync = took_sync;
			end
		end
		// Emitting a timestamp restarts the delta count
		if (launch) begin
			nxt_st.lts_pend = 1'b0;
			nxt_st.ts_cnt   = '0;
		end
		// A data packet captures the delta so its timestamp stays synchronous
		if ((took_stim || took_hw) && ts_enable_in) begin
			nxt_st.lts_pend = 1'b1;
			nxt_st.lts_val  = cur_ff.ts_cnt;
		end

		// Pending flags: a new event in the taking cycle wins over the clear
		nxt_st.ovf_pend  = cur_ff.ovf_pend & ~took_ovf;
		nxt_st.sync_pend = cur_ff.sync_pend & ~took_sync;
		nxt_st.gts_pend  = cur_ff.gts_pend & ~took_gts;
		if (took_stim) begin
			nxt_st.stim_full = 1'b0;
		end
		if (took_hw) begin
			nxt_st.hw_full = 1'b0;
		end
		if (sync_on && cur_ff.sync_cnt >= SYNC_PERIOD - 32'h0000_0001) begin
			nxt_st.sync_pend = 1'b1;
		end
		if (ts_enable_in && cur_ff.ts_cnt == TPF_TS_MAX && !launch) begin
			nxt_st.ovf_pend = 1'b1;
		end
		if (gts_req_in) begin
			nxt_st.gts_pend = 1'b1;
			nxt_st.gts_val  = gts_value_in;
		end

		// Stimulus slot; a write into a full slot is dropped and flagged
		if (stim_valid_in) begin
			if (cur_ff.stim_full) begin
				nxt_st.ovf_pend = 1'b1;
			end else begin
				nxt_st.stim_full = 1'b1;
				nxt_st.stim_port = stim_port_in;
				nxt_st.stim_data = stim_data_in;
				nxt_st.stim_size = stim_size_in;
			end
		end

		// Watchpoint slot behaves the same way
		if (hw_valid_in) begin
			if (cur_ff.hw_full) begin
				nxt_st.ovf_pend = 1'b1;
			end else begin
				nxt_st.hw_full = 1'b1;
				nxt_st.hw_id   = hw_id_in;
				nxt_st.hw_data = hw_data_in;
				nxt_st.hw_size = hw_size_in;
			end
		end

		// Serializer: loads a byte when empty or on its last bit, shifts out LSB first
		if (cur_ff.ser_cnt != 4'h0) begin
			nxt_st.ser_sh  = {1'b0, cur_ff.ser_sh[7:1]};
			nxt_st.ser_cnt = cur_ff.ser_cnt - 4'h1;
		end
		if (serial_mode_in && fifo_out_valid && fifo_out_ready) begin
			nxt_st.ser_sh  = fifo_out_data;
			nxt_st.ser_cnt = 4'h8;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cur_ff <= '0;
		end else if (ce_in) begin
			cur_ff <= nxt_st;
		end
	end

	// The serializer must be empty or on its last bit before taking a byte
	assign fifo_out_ready = serial_mode_in ? (cur_ff.ser_cnt <= 4'h1) : byte_ready_in;

	tpf_fifo #(
		.W(8),
		.D(32)
	) u_fifo (
		.clk_sys_in    (clk_sys_in),
		.rst_in        (rst_in),
		.ce_in         (ce_in),
		.in_valid_in   (fifo_in_valid),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (fifo_in_data),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign stim_ready_out      = !cur_ff.stim_full;
	assign hw_ready_out        = !cur_ff.hw_full;
	assign byte_valid_out      = fifo_out_valid && !serial_mode_in;
	assign byte_data_out       = fifo_out_data;
	assign trace_bit_out       = cur_ff.ser_sh[0];
	assign trace_bit_valid_out = (cur_ff.ser_cnt != 4'h0);
	assign page_out            = cur_ff.page;
endmodule

// *** tpf_pkg.sv ***
// Purpose: Shared constants and types for the trace packet formatter.
// Assumes: All users run on clk_sys_in at 20 MHz.
// Notes:   Header values and byte counts follow the trace packet protocol.
package tpf_pkg;

	////////////////////////////////////////////////////////////////////////
	// Header encodings
	localparam logic [7:0] TPF_HDR_SYNC     = 8'h00;   // Sync filler byte
	localparam logic [7:0] TPF_SYNC_END     = 8'h80;   // Closing byte of a sync run
	localparam logic [7:0] TPF_HDR_OVF      = 8'h70;   // Overflow header
	localparam logic [7:0] TPF_HDR_LTS1     = 8'hC0;   // Long timestamp, TC = 00
	localparam logic [7:0] TPF_HDR_GTS1     = 8'h94;   // Global timestamp, low bits
	localparam logic [3:0] TPF_LTS_LOW      = 4'h0;    // Low nibble of timestamp header
	localparam logic [3:0] TPF_EXT_LOW      = 4'h8;    // Low nibble, extension, S = 0
	localparam logic [1:0] TPF_SRC_PROTO    = 2'h0;    // Low bits of protocol headers
	localparam logic [0:0] TPF_SW_SRC       = 1'h0;    // Software source select bit

	////////////////////////////////////////////////////////////////////////
	// Lengths and field widths
	localparam logic [2:0] TPF_SYNC_LEN     = 3'h7;    // Six zero bytes and the end byte
	localparam logic [2:0] TPF_GTS_LEN      = 3'h5;    // Header and four payload bytes
	localparam logic [2:0] TPF_ONE_BYTE     = 3'h1;
	localparam int         TPF_GRP_W        = 7;       // Value bits per payload byte
	localparam int         TPF_TS_W         = 28;      // Local timestamp counter width
	localparam int         TPF_GTS_W        = 26;      // Global timestamp low part
	localparam logic [27:0] TPF_TS_SHORT_MIN = 28'h000_0001;
	localparam logic [27:0] TPF_TS_SHORT_MAX = 28'h000_0006;
	localparam logic [27:0] TPF_TS_1B_LIM   = 28'h000_0080;
	localparam logic [27:0] TPF_TS_2B_LIM   = 28'h000_4000;
	localparam logic [27:0] TPF_TS_3B_LIM   = 28'h020_0000;
	localparam logic [27:0] TPF_TS_MAX      = 28'hFFF_FFFF;
	localparam logic [31:0] TPF_SYNC_PERIOD = 32'h0000_2000;   // Cycles between syncs

	// Formatter states
	typedef enum logic [0:0] {
		TPF_IDLE,
		TPF_EMIT
	} tpf_state_t;

endpackage

// *** tpf_formatter_asserts.sv ***
// Purpose: Concurrent checks on the ports of the trace packet formatter.
// Assumes: One clock domain, synchronous active high reset, ce_in held high.
// Notes:   Bound to every formatter instance below the module.
`timescale 1ns/1ps

module tpf_formatter_asserts #(
	parameter logic [31:0] SYNC_PERIOD = 32'h0000_2000
) (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_in,
	input  wire logic       ce_in,
	input  wire logic       stim_valid_in,
	input  wire logic       stim_ready_out,
	input  wire logic       hw_valid_in,
	input  wire logic       hw_ready_out,
	input  wire logic       serial_mode_in,
	input  wire logic       byte_valid_out,
	input  wire logic       byte_ready_in,
	input  wire logic [7:0] byte_data_out,
	input  wire logic       trace_bit_valid_out,
	input  wire logic [2:0] page_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	////////////////////////////////////////////////////////////////////////
	// Reset leaves the stream idle, both slots free and the page at zero
	a_reset_idle: assert property ($fell(rst_in) |-> !byte_valid_out && stim_ready_out
		&& hw_ready_out && !trace_bit_valid_out && page_out == 3'h0)
		else $error("outputs not idle after reset");
	// A taken request occupies its slot on the next cycle
	a_stim_taken: assert property (ce_in && stim_valid_in && stim_ready_out |=>
		!stim_ready_out) else $error("stimulus slot not taken");
	a_hw_taken: assert property (ce_in && hw_valid_in && hw_ready_out |=>
		!hw_ready_out) else $error("watchpoint slot not taken");
	// A held stimulus slot is launched into the merged stream in bounded time
	a_stim_return: assert property (!stim_ready_out |-> ##[0:1000] stim_ready_out)
		else $error("stimulus slot never freed");
	// A stalled byte stays put so packet order survives backpressure
	a_byte_hold: assert property (byte_valid_out && !byte_ready_in |=>
		byte_valid_out && $stable(byte_data_out)) else $error("byte changed while stalled");
	a_serial_route: assert property (serial_mode_in |-> !byte_valid_out)
		else $error("byte port active in serial mode");
	// Every serial byte is eight bit times
	a_bit_count: assert property ($rose(trace_bit_valid_out) |->
		trace_bit_valid_out [*8]) else $error("serial byte shorter than eight bits");
	// A write into a full slot turns into an overflow header
	a_ovf_stim: assert property (ce_in && stim_valid_in && !stim_ready_out |->
		##[1:1000] (byte_valid_out && byte_data_out == 8'h70))
		else $error("no overflow after refused stimulus write");
	a_ovf_hw: assert property (ce_in && hw_valid_in && !hw_ready_out |->
		##[1:1000] (byte_valid_out && byte_data_out == 8'h70))
		else $error("no overflow after refused watchpoint packet");
endmodule

bind tpf_formatter tpf_formatter_asserts #(.SYNC_PERIOD(SYNC_PERIOD)) u_chk (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
	.stim_valid_in(stim_valid_in), .stim_ready_out(stim_ready_out),
	.hw_valid_in(hw_valid_in), .hw_ready_out(hw_ready_out),
	.serial_mode_in(serial_mode_in), .byte_valid_out(byte_valid_out),
	.byte_ready_in(byte_ready_in), .byte_data_out(byte_data_out),
	.trace_bit_valid_out(trace_bit_valid_out), .page_out(page_out)
);

// *** tpf_sink.sv ***
// Purpose: Trace sink model taking the byte stream and the serial bits.
// Assumes: mode_in 0 takes every byte, 1 every other cycle, 2 stalls.
// Notes:   Bytes and rebuilt serial bytes wait in queues for the bench.
`timescale 1ns/1ps

module tpf_sink (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_in,
	input  wire logic [1:0] mode_in,
	input  wire logic       byte_valid_in,
	input  wire logic [7:0] byte_data_in,
	input  wire logic       bit_in,
	input  wire logic       bit_valid_in,
	output logic            byte_ready_out = 1'b0
);
	logic [7:0] q[$];
	logic [7:0] sq[$];
	logic [7:0] sh_ff = 8'h00;
	logic       tog = 1'b0;
	int         nb = 0;

	////////////////////////////////////////////////////////////////////////
	// Ready moves on the falling edge; slow mode halves the take rate
	always @(negedge clk_sys_in) begin
		tog <= ~tog;
		byte_ready_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && tog);
	end

	// A byte is taken where valid and ready meet, header first
	always @(posedge clk_sys_in) begin
		if (!rst_in && byte_valid_in && byte_ready_out) begin
			q.push_back(byte_data_in);
		end
	end

	// Serial bits rebuilt LSB first; no byte alignment is demanded of sync runs
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			nb = 0;
		end else if (bit_valid_in) begin
			sh_ff = {bit_in, sh_ff[7:1]};
			nb = nb + 1;
			if (nb == 8) begin
				sq.push_back(sh_ff);
				nb = 0;
			end
		end
	end
endmodule

// *** tpf_formatter_bench.sv ***
// Purpose: Self-checking bench for the trace packet formatter.
// Assumes: Sink model on the byte port; inputs change on the falling edge.
// Notes:   Sync period cut to 16 cycles so the run stays short.
`timescale 1ns/1ps

module tpf_formatter_bench;
	import tpf_pkg::*;

	localparam logic [31:0] PERIOD = 32'h0000_0010;

	logic        clk_sys_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        ce_in = 1'b1;
	logic        stim_valid_in = 1'b0;
	logic        hw_valid_in = 1'b0;
	logic        ts_enable_in = 1'b0;
	logic        gts_req_in = 1'b0;
	logic        sync_enable_in = 1'b0;
	logic        parallel_port_in = 1'b0;
	logic        serial_mode_in = 1'b0;
	logic [7:0]  stim_port_in = 8'h00;
	logic [31:0] stim_data_in = 32'h0000_0000;
	logic [1:0]  stim_size_in = 2'h0;
	logic [4:0]  hw_id_in = 5'h00;
	logic [31:0] hw_data_in = 32'h0000_0000;
	logic [1:0]  hw_size_in = 2'h0;
	logic [25:0] gts_value_in = 26'h000_0000;
	logic [1:0]  sink_mode = 2'h1;
	logic        stim_ready_out, hw_ready_out, byte_valid_out, byte_ready_in;
	logic        trace_bit_out, trace_bit_valid_out;
	logic [7:0]  byte_data_out;
	logic [2:0]  page_out;
	int          err_total = 0;
	int          n_compared = 0;

	////////////////////////////////////////////////////////////////////////
	// Design, sink and clock
	tpf_formatter #(.SYNC_PERIOD(PERIOD)) DUT (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
		.stim_valid_in(stim_valid_in), .stim_port_in(stim_port_in),
		.stim_data_in(stim_data_in), .stim_size_in(stim_size_in),
		.stim_ready_out(stim_ready_out), .hw_valid_in(hw_valid_in), .hw_id_in(hw_id_in),
		.hw_data_in(hw_data_in), .hw_size_in(hw_size_in), .hw_ready_out(hw_ready_out),
		.ts_enable_in(ts_enable_in), .gts_req_in(gts_req_in), .gts_value_in(gts_value_in),
		.parallel_port_in(parallel_port_in), .sync_enable_in(sync_enable_in),
		.serial_mode_in(serial_mode_in), .byte_valid_out(byte_valid_out),
		.byte_ready_in(byte_ready_in), .byte_data_out(byte_data_out),
		.trace_bit_out(trace_bit_out), .trace_bit_valid_out(trace_bit_valid_out),
		.page_out(page_out)
	);
	tpf_sink SNK (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .mode_in(sink_mode),
		.byte_valid_in(byte_valid_out), .byte_data_in(byte_data_out),
		.bit_in(trace_bit_out), .bit_valid_in(trace_bit_valid_out),
		.byte_ready_out(byte_ready_in)
	);
	always #25 clk_sys_in = ~clk_sys_in;

	////////////////////////////////////////////////////////////////////////
	// Shared helpers; waits are bounded so a hang shows as a mismatch
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	function automatic bit has(input logic [7:0] v);
		has = 1'b0;
		foreach (SNK.q[i]) begin
			if (SNK.q[i] === v) has = 1'b1;
		end
	endfunction
	task automatic wait_n(input int n);
		int k;
		k = 0;
		while (SNK.q.size() < n && k < 3000) begin
			tick(1);
			k++;
		end
		tick(10);
	endtask
	task automatic expect_q(input logic [7:0] e[$]);
		wait_n(e.size());
		foreach (e[i]) chk_byte(SNK.q[i], e[i]);
		chk_flag(SNK.q.size() == e.size(), 1'b1);
		SNK.q.delete();
	endtask
	// One request pulse of len cycles; len 2 hits a full slot on purpose
	task automatic send(input bit hw, input logic [7:0] id, input logic [31:0] d,
			input logic [1:0] sz, input int len);
		int k;
		k = 0;
		tick(1);
		while ((hw ? hw_ready_out : stim_ready_out) !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
		{stim_port_in, stim_data_in, stim_size_in} = {id, d, sz};
		{hw_id_in, hw_data_in, hw_size_in} = {id[4:0], d, sz};
		hw_valid_in = hw;
		stim_valid_in = !hw;
		tick(len);
		hw_valid_in = 1'b0;
		stim_valid_in = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_basic;
		send(1'b0, 8'h05, 32'h0000_00A5, 2'h0, 1);
		chk_flag(stim_ready_out, 1'b0);
		expect_q('{8'h29, 8'hA5});
		send(1'b1, 8'h09, 32'h0000_BEEF, 2'h1, 1);
		chk_flag(hw_ready_out, 1'b0);
		expect_q('{8'h4E, 8'hEF, 8'hBE});
	endtask
	// Stalled sink: 35 bytes overfill the 32-entry queue, then drain slowly
	task automatic t_fifo;
		logic [7:0] e[$];
		sink_mode = 2'h2;
		for (int i = 0; i < 7; i++) begin
			send(1'b0, 8'h05, 32'h1122_3344, 2'h3, 1);
			e = {e, 8'h2B, 8'h44, 8'h33, 8'h22, 8'h11};
		end
		tick(10);
		chk_flag(byte_valid_out, 1'b1);
		chk_byte(byte_data_out, 8'h2B);
		chk_flag(SNK.q.size() == 0, 1'b1);
		sink_mode = 2'h1;
		expect_q(e);
		sink_mode = 2'h0;
	endtask
	task automatic t_ovf;
		for (int h = 0; h < 2; h++) begin
			send(h[0], 8'h05, 32'h0000_00A5, 2'h0, 2);
			wait_n(3);
			chk_flag(has(8'h70), 1'b1);
			chk_flag(SNK.q.size() == 3, 1'b1);
			SNK.q.delete();
		end
	endtask
	task automatic t_global;
		logic [25:0] v;
		v = 26'h2AB_CDEF;
		gts_value_in = v;
		gts_req_in = 1'b1;
		tick(1);
		gts_req_in = 1'b0;
		expect_q('{8'h94, {1'b1, v[6:0]}, {1'b1, v[13:7]}, {1'b1, v[20:14]}, {3'h0, v[25:21]}});
	endtask
	// Long delta first, then a short one proves the counter was cleared
	task automatic t_stamp;
		logic [13:0] v;
		logic [7:0]  b;
		ts_enable_in = 1'b1;
		tick(150);
		send(1'b0, 8'h05, 32'h0000_00A5, 2'h0, 1);
		send(1'b0, 8'h05, 32'h0000_00A5, 2'h0, 1);
		wait_n(8);
		v = {SNK.q[4][6:0], SNK.q[3][6:0]};
		chk_byte(SNK.q[2], TPF_HDR_LTS1);
		chk_flag(SNK.q[3][7] & ~SNK.q[4][7], 1'b1);
		chk_flag(v >= 14'd148 && v <= 14'd170, 1'b1);
		b = SNK.q[7];
		if (b[7] === 1'b0) begin
			chk_flag(b[3:0] == 4'h0 && b[6:4] >= 3'h1 && b[6:4] <= 3'h6, 1'b1);
		end else begin
			chk_byte(b, TPF_HDR_LTS1);
			chk_flag(SNK.q[8] >= 8'h07 && SNK.q[8] <= 8'h10, 1'b1);
		end
		ts_enable_in = 1'b0;
		SNK.q.delete();
	endtask
	task automatic t_serial;
		int k;
		k = 0;
		serial_mode_in = 1'b1;
		send(1'b0, 8'h05, 32'h0000_00A5, 2'h0, 1);
		while (SNK.sq.size() < 2 && k < 500) begin
			tick(1);
			k++;
		end
		chk_byte(SNK.sq[0], 8'h29);
		chk_byte(SNK.sq[1], 8'hA5);
		chk_flag(SNK.q.size() == 0, 1'b1);
		tick(4);
		serial_mode_in = 1'b0;
	endtask
	task automatic t_page;
		send(1'b0, 8'h62, 32'hDDCC_BBAA, 2'h2, 1);
		expect_q('{8'h38, 8'h13, 8'hAA, 8'hBB, 8'hCC, 8'hDD});
		chk_flag(page_out === 3'h3, 1'b1);
	endtask
	// Serial enable, then parallel port; sync is switched off once seven bytes arrive so only one goes out
	task automatic t_sync;
		int k;
		for (int m = 0; m < 2; m++) begin
			k = 0;
			{parallel_port_in, sync_enable_in} = m[0] ? 2'b10 : 2'b01;
			while (SNK.q.size() < 7 && k < 500) begin
				tick(1);
				k++;
			end
			{parallel_port_in, sync_enable_in} = 2'b00;
			tick(20);
			for (int i = 0; i < 6; i++) chk_byte(SNK.q[i], TPF_HDR_SYNC);
			chk_byte(SNK.q[6], TPF_SYNC_END);
			chk_flag(SNK.q.size() == 7, 1'b1);
			chk_flag(page_out === 3'h0, 1'b1);
			SNK.q.delete();
			t_page();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Verdict, main sequence and watchdog
	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		tick(5);
		rst_in = 1'b0;
		t_basic();
		t_fifo();
		t_ovf();
		t_global();
		t_stamp();
		t_serial();
		t_page();
		t_sync();
		results();
	end
	initial begin
		#(20000 * 50);
		err_total++;
		results();
	end
endmodule
